// file: pmaed_decoder.sv
`timescale 1ns/10ps
module pmaed_decoder (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic CYC_VALID,
    input wire logic CYC_MEM,
    input wire logic CYC_WRITE,
    input wire logic CYC_VLB,
    input wire logic CYC_IDE_INT,
    input wire logic [23:0] CYC_ADDR,
    input wire logic [7:0] TIMER_TIMEOUT,
    output logic SERIAL_A_EVENT,
    output logic SERIAL_B_EVENT,
    output logic DISK_EVENT,
    output logic INTEGRATED_DRIVE_EVENT,
    output logic KEYBOARD_EVENT,
    output logic VIDEO_EVENT,
    output logic GENERAL_RANGE_ONE_EVENT,
    output logic GENERAL_RANGE_TWO_EVENT,
    output logic PRINTER_PORT_GROUP_EVENT,
    output logic [3:0] CHIP_SELECT_EVENT,
    output logic [3:0] CHIP_SELECT_LINES_N,
    output logic IDLE_RELOAD,
    output logic DOZE_RELOAD,
    output logic [1:0] GENERAL_RANGE_PMI,
    output logic NEXT_ACCESS_SMI,
    output logic AHOLD
);
    typedef struct packed {
        logic [pmaed_pkg::NUM_SLOTS-1:0][7:0] regs;
        logic [7:0] rdata;
        logic valid_q;
        logic [7:0] expired;
        logic [1:0] gr_started;
        pmaed_pkg::pmaed_hold_type hold;
        logic [3:0] hold_cnt;
        logic [7:0] ev;
        logic printer_ev;
        logic [3:0] cs_ev;
        logic [3:0] cs_n;
        logic idle_rl;
        logic doze_rl;
        logic [1:0] gr_pmi;
        logic smi;
        logic ahold;
    } pmaed_state_type;

    pmaed_state_type s_reg;
    pmaed_state_type s_next;

    function automatic logic io_in(input logic [23:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
        io_in = (a[15:0] >= lo) && (a[15:0] <= hi);
    endfunction : io_in

    // Ten compare bits: A[9:0] for I/O, A[23:14] for memory
    function automatic logic gr_hit(input logic [23:0] a,
                                    input logic mem,
                                    input logic wr,
                                    input logic [7:0] base,
                                    input logic [7:0] ctl,
                                    input logic mode,
                                    input logic a0,
                                    input logic m0);
        logic [9:0] cmp;
        logic [9:0] ref_bits;
        logic [9:0] msk;
        cmp = mem ? a[23:14] : a[9:0];
        ref_bits = {ctl[7], base, a0};
        msk = {4'h0, ctl[4:0], m0};
        gr_hit = (mem == mode) && ((cmp ^ ref_bits) & ~msk) == 10'h000
            && (wr ? ctl[pmaed_pkg::CTL_WRITE] : ctl[pmaed_pkg::CTL_READ]);
    endfunction : gr_hit

    // Select base: A[9:2] I/O or A[23:16] memory; ctl[7] picks memory
    function automatic logic cs_hit(input logic [23:0] a,
                                    input logic mem,
                                    input logic wr,
                                    input logic [7:0] base,
                                    input logic [7:0] ctl);
        logic [7:0] cmp;
        cmp = mem ? a[23:16] : a[9:2];
        cs_hit = (mem == ctl[7]) && ((cmp ^ base) & {3'h7, ~ctl[4:0]}) == 8'h00
            && (wr ? ctl[pmaed_pkg::CTL_WRITE] : ctl[pmaed_pkg::CTL_READ]);
    endfunction : cs_hit

    logic [7:0] vr;
    logic [7:0] ds;
    logic [7:0] vb;
    logic [7:0] idle_a;
    logic [7:0] idle_b;
    logic [7:0] en;
    logic [7:0] feat;
    logic [7:0] next_en;
    logic start;
    logic io;
    logic fdd;
    logic hdd;
    logic ide_rng;
    logic vid_rng;
    logic vid_bus;
    logic printer_hit;
    logic [7:0] hit;
    logic [3:0] cs_dec;
    logic [3:0] cs_now;
    logic [7:0] trap;
    logic video_trap;
    logic [4:0] wslot;
    logic [4:0] rslot;

    assign vr = s_reg.regs[0];
    assign ds = s_reg.regs[1];
    assign vb = s_reg.regs[2];
    assign idle_a = s_reg.regs[5];
    assign idle_b = s_reg.regs[6];
    assign next_en = {s_reg.regs[8][3:0], s_reg.regs[7][3:0]};
    assign feat = s_reg.regs[14];
    assign en = s_reg.regs[23];
    // One decode per cycle, however long the cycle lasts
    assign start = CYC_VALID & ~s_reg.valid_q;
    assign io = ~CYC_MEM;
    assign printer_hit = start & io & (io_in(CYC_ADDR, 16'h0378, 16'h037f)
        | io_in(CYC_ADDR, 16'h0278, 16'h027f)
        | io_in(CYC_ADDR, 16'h03b8, 16'h03bf));
    assign fdd = io & (CYC_ADDR[15:0] == 16'h03f5)
        & ~ds[pmaed_pkg::DS_FDD_OFF];
    assign hdd = io & (io_in(CYC_ADDR, 16'h01f0, 16'h01f7)
        | CYC_ADDR[15:0] == 16'h03f6) & ~ds[pmaed_pkg::DS_HDD_OFF];
    assign ide_rng = s_reg.regs[9][pmaed_pkg::IDE_SECONDARY]
        ? (io_in(CYC_ADDR, 16'h0170, 16'h0177) | CYC_ADDR[15:0] == 16'h0377)
        : (io_in(CYC_ADDR, 16'h01f0, 16'h01f7) | CYC_ADDR[15:0] == 16'h03f6);
    assign vid_rng = (io & io_in(CYC_ADDR, 16'h03b0, 16'h03df)
            & ~vr[pmaed_pkg::VR_IO_OFF])
        | (CYC_MEM & CYC_ADDR >= 24'h0a0000 & CYC_ADDR <= 24'h0bffff
            & ~vr[pmaed_pkg::VR_MEM_OFF]);
    assign vid_bus = (~CYC_VLB & ~vb[pmaed_pkg::VB_AT_OFF])
        | (CYC_VLB & vb[pmaed_pkg::VB_VL_ON]);

    always_comb begin
        hit = 8'h00;
        hit[pmaed_pkg::SRC_SERA] = start & io & en[0]
            & io_in(CYC_ADDR, 16'h03f8, 16'h03ff);
        hit[pmaed_pkg::SRC_SERB] = start & io & en[1]
            & io_in(CYC_ADDR, 16'h02f8, 16'h02ff);
        hit[pmaed_pkg::SRC_DISK] = start & en[2] & (fdd | hdd);
        // Internal IDE claim only; disk mask bits play no part
        hit[pmaed_pkg::SRC_IDE] = start & io & en[3] & CYC_IDE_INT
            & ide_rng;
        hit[pmaed_pkg::SRC_KBD] = start & io & en[4]
            & (CYC_ADDR[15:0] == 16'h0060 | CYC_ADDR[15:0] == 16'h0064);
        hit[pmaed_pkg::SRC_VIDEO] = start & en[5] & vid_rng & vid_bus;
        hit[pmaed_pkg::SRC_GR1] = start & gr_hit(CYC_ADDR, CYC_MEM, CYC_WRITE,
            s_reg.regs[10], s_reg.regs[11], feat[4], feat[2], feat[0]);
        hit[pmaed_pkg::SRC_GR2] = start & gr_hit(CYC_ADDR, CYC_MEM, CYC_WRITE,
            s_reg.regs[12], s_reg.regs[13], feat[5], feat[3], feat[1]);
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cs_dec[i] = cs_hit(CYC_ADDR, CYC_MEM, CYC_WRITE,
                s_reg.regs[15 + 2 * i], s_reg.regs[16 + 2 * i]);
        end
    end

    assign cs_now = cs_dec & {4{CYC_VALID}};

    // General ranges trap only on writes; others on any access
    always_comb begin
        trap = hit & s_reg.expired & next_en;
        trap[pmaed_pkg::SRC_GR1] = trap[pmaed_pkg::SRC_GR1] & CYC_WRITE;
        trap[pmaed_pkg::SRC_GR2] = trap[pmaed_pkg::SRC_GR2] & CYC_WRITE;
    end

    assign video_trap = trap[pmaed_pkg::SRC_VIDEO]
        & s_reg.regs[3][pmaed_pkg::HOLD_EN];
    assign wslot = pmaed_pkg::slot_of(REG_ADDR);
    assign rslot = wslot;

    always_comb begin
        s_next = s_reg;
        s_next.valid_q = CYC_VALID;
        // Register port
        if (REG_WR && wslot < pmaed_pkg::SLOT_STATUS) begin
            s_next.regs[wslot] = REG_WDATA;
        end
        if (REG_RD && rslot < pmaed_pkg::SLOT_STATUS) begin
            s_next.rdata = s_reg.regs[rslot];
        end else if (REG_RD && rslot == pmaed_pkg::SLOT_STATUS) begin
            s_next.rdata = s_reg.expired;
        end else begin
            s_next.rdata = 8'h00;
        end
        // Access reloads the counter, so expiry clears; timeout set wins
        s_next.expired = (s_reg.expired & ~hit) | TIMER_TIMEOUT;
        // First write starts a range counter
        if (hit[pmaed_pkg::SRC_GR1] && CYC_WRITE) begin
            s_next.gr_started[0] = 1'b1;
        end
        if (hit[pmaed_pkg::SRC_GR2] && CYC_WRITE) begin
            s_next.gr_started[1] = 1'b1;
        end
        s_next.gr_pmi = {TIMER_TIMEOUT[pmaed_pkg::SRC_GR2],
            TIMER_TIMEOUT[pmaed_pkg::SRC_GR1]} & s_reg.gr_started;
        // Events double as counter reloads
        s_next.ev = hit;
        s_next.printer_ev = printer_hit;
        s_next.cs_ev = cs_dec & {4{start}};
        s_next.cs_n = ~cs_now;
        s_next.idle_rl = (printer_hit & idle_a[5])
            | (hit[pmaed_pkg::SRC_VIDEO] & idle_a[0])
            | (hit[pmaed_pkg::SRC_DISK] & idle_a[1])
            | (hit[pmaed_pkg::SRC_KBD] & idle_a[2])
            | (hit[pmaed_pkg::SRC_GR1] & idle_a[3])
            | (hit[pmaed_pkg::SRC_IDE] & idle_b[2])
            | (hit[pmaed_pkg::SRC_GR2] & idle_b[3])
            | (hit[pmaed_pkg::SRC_SERA] & idle_b[4])
            | (hit[pmaed_pkg::SRC_SERB] & idle_b[5])
            | (|(cs_dec & {4{start}} & {idle_b[7:6], idle_a[7:6]}));
        s_next.doze_rl = s_reg.regs[4][pmaed_pkg::DOZE_RELOAD]
            & ((printer_hit & idle_a[5])
            | (hit[pmaed_pkg::SRC_VIDEO] & idle_a[0])
            | (hit[pmaed_pkg::SRC_DISK] & idle_a[1])
            | (hit[pmaed_pkg::SRC_KBD] & idle_a[2])
            | (hit[pmaed_pkg::SRC_IDE] & idle_b[2]));
        // Traps not held by the sequencer raise SMI at once
        s_next.smi = |(trap & ~{7'h00, video_trap});
        case (s_reg.hold)
            pmaed_pkg::HS_IDLE: begin
                s_next.ahold = 1'b0;
                if (video_trap) begin
                    s_next.hold = pmaed_pkg::HS_HOLD;
                    s_next.hold_cnt = pmaed_pkg::HOLD_CYCLES;
                    s_next.ahold = 1'b1;
                end
            end
            pmaed_pkg::HS_HOLD: begin
                // Give the CPU time to back off before SMI lands
                s_next.hold_cnt = s_reg.hold_cnt - 4'h1;
                if (s_reg.hold_cnt == 4'h1) begin
                    s_next.hold = pmaed_pkg::HS_SMI;
                    s_next.smi = 1'b1;
                end
            end
            pmaed_pkg::HS_SMI: begin
                s_next.hold = pmaed_pkg::HS_IDLE;
                s_next.ahold = 1'b0;
            end
            default: begin
                s_next.hold = pmaed_pkg::HS_IDLE;
                s_next.ahold = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_reg <= '{regs: '{default: pmaed_pkg::REG_RESET},
                       hold: pmaed_pkg::HS_IDLE,
                       cs_n: 4'hf,
                       default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign REG_RDATA = s_reg.rdata;
    assign SERIAL_A_EVENT = s_reg.ev[pmaed_pkg::SRC_SERA];
    assign SERIAL_B_EVENT = s_reg.ev[pmaed_pkg::SRC_SERB];
    assign DISK_EVENT = s_reg.ev[pmaed_pkg::SRC_DISK];
    assign INTEGRATED_DRIVE_EVENT = s_reg.ev[pmaed_pkg::SRC_IDE];
    assign KEYBOARD_EVENT = s_reg.ev[pmaed_pkg::SRC_KBD];
    assign VIDEO_EVENT = s_reg.ev[pmaed_pkg::SRC_VIDEO];
    assign GENERAL_RANGE_ONE_EVENT = s_reg.ev[pmaed_pkg::SRC_GR1];
    assign GENERAL_RANGE_TWO_EVENT = s_reg.ev[pmaed_pkg::SRC_GR2];
    assign PRINTER_PORT_GROUP_EVENT = s_reg.printer_ev;
    assign CHIP_SELECT_EVENT = s_reg.cs_ev;
    assign CHIP_SELECT_LINES_N = s_reg.cs_n;
    assign IDLE_RELOAD = s_reg.idle_rl;
    assign DOZE_RELOAD = s_reg.doze_rl;
    assign GENERAL_RANGE_PMI = s_reg.gr_pmi;
    assign NEXT_ACCESS_SMI = s_reg.smi;
    // Outside logic may gate this into a CPU backoff
    assign AHOLD = s_reg.ahold;

    hold_first_a: assert property (@(posedge CLK) disable iff (!RST_N)
        video_trap && s_reg.hold == pmaed_pkg::HS_IDLE
        |=> AHOLD && !NEXT_ACCESS_SMI ##1 AHOLD
            ##1 AHOLD && NEXT_ACCESS_SMI)
        else $error("hold not raised ahead of SMI");
    hold_smi_order_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(AHOLD) |-> !NEXT_ACCESS_SMI ##2 NEXT_ACCESS_SMI && AHOLD)
        else $error("SMI not raised while hold stands");
    hold_release_a: assert property (@(posedge CLK) disable iff (!RST_N)
        AHOLD && NEXT_ACCESS_SMI |=> !AHOLD)
        else $error("hold stays after SMI");
    event_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CYC_VALID [*3] |=> !(VIDEO_EVENT || DISK_EVENT || KEYBOARD_EVENT))
        else $error("event repeated within one cycle");
    floppy_mask_a: assert property (@(posedge CLK) disable iff (!RST_N)
        start && io && CYC_ADDR[15:0] == 16'h03f5
            && ds[pmaed_pkg::DS_FDD_OFF] |=> !DISK_EVENT)
        else $error("excluded floppy access raised disk event");
    ide_alone_a: assert property (@(posedge CLK) disable iff (!RST_N)
        start && !CYC_IDE_INT |=> !INTEGRATED_DRIVE_EVENT)
        else $error("drive event without internal decode");
    video_bus_a: assert property (@(posedge CLK) disable iff (!RST_N)
        start && CYC_VLB && !vb[pmaed_pkg::VB_VL_ON] |=> !VIDEO_EVENT)
        else $error("VL video access not masked");
    gr_read_trap_a: assert property (@(posedge CLK) disable iff (!RST_N)
        hit[pmaed_pkg::SRC_GR1] && !CYC_WRITE && trap == 8'h00
            && s_reg.hold == pmaed_pkg::HS_IDLE |=> !NEXT_ACCESS_SMI)
        else $error("read raised range trap");
    kbd_idle_a: assert property (@(posedge CLK) disable iff (!RST_N)
        hit[pmaed_pkg::SRC_KBD] && idle_a[2] |=> KEYBOARD_EVENT && IDLE_RELOAD)
        else $error("keyboard access did not reload idle");
    doze_excl_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !s_reg.regs[4][pmaed_pkg::DOZE_RELOAD] |=> !DOZE_RELOAD)
        else $error("doze reload while disabled");
endmodule : pmaed_decoder

// file: pmaed_pkg.sv
// Summary of operation
// - Printer port ranges form one group that may reload the idle timer.
// - Each serial range enabled alone; raises its event, counter and idle reload.
// - Disk event is floppy OR hard disk; reloads disk and optionally idle timer.
// - Floppy data port counts toward disk event only while its exclude bit is zero.
// - Primary hard disk ports count while exclude bit is zero, any bus.
// - Integrated IDE accesses raise their event; select bit picks primary or secondary.
// - Integrated drive event uses only the internal IDE decode, not disk bits.
// - Keyboard ports raise keyboard event, reload keyboard and idle timers.
// - Video I/O and memory ranges each included while their mask bit is zero.
// - Video event reloads timers; AT-bus included on bit7 zero, VL-bus on bit6 one.
// - With hold bit set, next video access after expiry raises hold before SMI.
// - Hold drops once SMI has been raised in the hold sequence.
// - Four chip selects decode memory or I/O reads, writes or both.
// - Each chip select event can reload the idle timer through its own bit.
// - Two general range monitors, each with its own counter and any one range.
// - General range timeout with no activity raises an SMI-capable interrupt.
// - Memory mode compares address bits 23 to 14 instead of 9 to 0.
// - In memory mode read and write enables qualify memory cycles.
// - After timeout, next qualifying write to a trapped range raises SMI and reloads.
// - Enabled non-general, non-serial, non-select events reload doze when enabled.
package pmaed_pkg;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] VIDEO_RANGE_SELECT_OFS = 8'h43;
    localparam logic [7:0] DISK_SOURCE_SELECT_OFS = 8'h57;
    localparam logic [7:0] VIDEO_BUS_SELECT_OFS = 8'h5f;
    localparam logic [7:0] NEXT_ACCESS_HOLD_OFS = 8'hd5;
    localparam logic [7:0] DOZE_CONTROL_OFS = 8'h41;
    localparam logic [7:0] IDLE_RELOAD_A_OFS = 8'h4e;
    localparam logic [7:0] IDLE_RELOAD_B_OFS = 8'hbe;
    localparam logic [7:0] NEXT_TRAP_A_OFS = 8'h5b;
    localparam logic [7:0] NEXT_TRAP_B_OFS = 8'hdb;
    localparam logic [7:0] IDE_SELECT_OFS = 8'hac;
    localparam logic [7:0] GR1_BASE_OFS = 8'h48;
    localparam logic [7:0] GR1_CTL_OFS = 8'h49;
    localparam logic [7:0] GR2_BASE_OFS = 8'hb8;
    localparam logic [7:0] GR2_CTL_OFS = 8'hb9;
    localparam logic [7:0] GR_FEATURE_OFS = 8'hae;
    localparam logic [7:0] CS0_BASE_OFS = 8'h4a;
    localparam logic [7:0] CS0_CTL_OFS = 8'h4b;
    localparam logic [7:0] CS1_BASE_OFS = 8'h4c;
    localparam logic [7:0] CS1_CTL_OFS = 8'h4d;
    localparam logic [7:0] CS2_BASE_OFS = 8'hbc;
    localparam logic [7:0] CS2_CTL_OFS = 8'hbd;
    localparam logic [7:0] CS3_BASE_OFS = 8'hba;
    localparam logic [7:0] CS3_CTL_OFS = 8'hbb;
    localparam logic [7:0] EVENT_ENABLE_OFS = 8'hc0;
    localparam logic [7:0] EXPIRED_STATUS_OFS = 8'hc1;
    localparam int NUM_SLOTS = 24;
    localparam logic [4:0] SLOT_NONE = 5'h1f;
    localparam logic [4:0] SLOT_STATUS = 5'h18;
    // Bit positions
    localparam int VR_IO_OFF = 7;
    localparam int VR_MEM_OFF = 6;
    localparam int DS_FDD_OFF = 5;
    localparam int DS_HDD_OFF = 4;
    localparam int VB_AT_OFF = 7;
    localparam int VB_VL_ON = 6;
    localparam int HOLD_EN = 0;
    localparam int DOZE_RELOAD = 1;
    localparam int IDE_SECONDARY = 2;
    localparam int CTL_WRITE = 6;
    localparam int CTL_READ = 5;
    // Source index: matches next-trap bits {db[3:0],5b[3:0]}
    localparam int SRC_VIDEO = 0;
    localparam int SRC_DISK = 1;
    localparam int SRC_KBD = 2;
    localparam int SRC_GR1 = 3;
    localparam int SRC_GR2 = 4;
    localparam int SRC_SERA = 5;
    localparam int SRC_SERB = 6;
    localparam int SRC_IDE = 7;
    localparam int CLK_PERIOD_NS = 4;
    localparam int HOLD_TIME_NS = 8;
    localparam logic [3:0] HOLD_CYCLES =
        4'((HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_HOLD = 3'b010,
        HS_SMI = 3'b100
    } pmaed_hold_type;
    function automatic logic [4:0] slot_of(input logic [7:0] a);
        case (a)
            VIDEO_RANGE_SELECT_OFS: slot_of = 5'h00;
            DISK_SOURCE_SELECT_OFS: slot_of = 5'h01;
            VIDEO_BUS_SELECT_OFS: slot_of = 5'h02;
            NEXT_ACCESS_HOLD_OFS: slot_of = 5'h03;
            DOZE_CONTROL_OFS: slot_of = 5'h04;
            IDLE_RELOAD_A_OFS: slot_of = 5'h05;
            IDLE_RELOAD_B_OFS: slot_of = 5'h06;
            NEXT_TRAP_A_OFS: slot_of = 5'h07;
            NEXT_TRAP_B_OFS: slot_of = 5'h08;
            IDE_SELECT_OFS: slot_of = 5'h09;
            GR1_BASE_OFS: slot_of = 5'h0a;
            GR1_CTL_OFS: slot_of = 5'h0b;
            GR2_BASE_OFS: slot_of = 5'h0c;
            GR2_CTL_OFS: slot_of = 5'h0d;
            GR_FEATURE_OFS: slot_of = 5'h0e;
            CS0_BASE_OFS: slot_of = 5'h0f;
            CS0_CTL_OFS: slot_of = 5'h10;
            CS1_BASE_OFS: slot_of = 5'h11;
            CS1_CTL_OFS: slot_of = 5'h12;
            CS2_BASE_OFS: slot_of = 5'h13;
            CS2_CTL_OFS: slot_of = 5'h14;
            CS3_BASE_OFS: slot_of = 5'h15;
            CS3_CTL_OFS: slot_of = 5'h16;
            EVENT_ENABLE_OFS: slot_of = 5'h17;
            EXPIRED_STATUS_OFS: slot_of = SLOT_STATUS;
            default: slot_of = SLOT_NONE;
        endcase
    endfunction : slot_of
endpackage : pmaed_pkg

// file: pmaed_cpu_model.sv
`timescale 1ns/10ps
module pmaed_cpu_model (
    input wire logic clk,
    input wire logic hold,
    output logic valid,
    output logic mem,
    output logic write,
    output logic vlb,
    output logic ide,
    output logic [23:0] addr
);
    initial begin
        valid = 1'b0;
        {mem, write, vlb, ide} = 4'h0;
        addr = 24'h000000;
    end
    // One bus cycle of len clocks, kind is {mem, write, vlb, ide}
    task automatic cycle(input logic [3:0] kind, input logic [23:0] a,
                         input int len);
        int n;
        n = 0;
        while (hold === 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        // A hold that never drops counts against the run
        if (n == 16) testbench.err_total++;
        @(posedge clk);
        valid <= 1'b1;
        {mem, write, vlb, ide} <= kind;
        addr <= a;
        repeat (len) @(posedge clk);
        valid <= 1'b0;
        // Stale qualifiers would hide a decoder that ignores valid
        {mem, write, vlb, ide} <= ~kind;
        addr <= ~a;
    endtask : cycle
endmodule : pmaed_cpu_model

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
    typedef struct {
        logic [7:0] ra;
        logic [7:0] rd;
        logic [3:0] kind;
        logic [23:0] a;
        logic [9:0] ex;
    } pmaed_row_type;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] tmo = 8'h00;
    logic clr = 1'b1;
    logic [7:0] reg_rdata;
    logic cyc_valid, cyc_mem, cyc_write, cyc_vlb, cyc_ide;
    logic [23:0] cyc_addr;
    logic sa, sb, dsk, drv, kbd, vid, g1, g2, prn, idle, doze, smi, ahold;
    logic [3:0] cse, csl;
    logic [1:0] power_mgmt_interrupt;
    logic [9:0] ev, seen;
    logic [3:0] pulses;
    logic [15:0] hist;
    int err_total = 0;
    int comparisons = 0;
    // Bits: doze, select 0, printer, video, keyboard, drive, disk,
    // serial b, serial a, idle
    pmaed_row_type rows[30] = '{
        '{8'h00, 8'h00, 4'h4, 24'h000060, 10'h021},
        '{8'h00, 8'h00, 4'h0, 24'h000064, 10'h021},
        '{8'h00, 8'h00, 4'h4, 24'h0003f8, 10'h003},
        '{8'h00, 8'h00, 4'h0, 24'h0003ff, 10'h003},
        '{8'h00, 8'h00, 4'h0, 24'h0002f8, 10'h005},
        '{8'h00, 8'h00, 4'h4, 24'h0003f5, 10'h009},
        '{8'h00, 8'h00, 4'h0, 24'h0001f0, 10'h009},
        '{8'h00, 8'h00, 4'h2, 24'h0003f6, 10'h009},
        '{8'h00, 8'h00, 4'h4, 24'h000378, 10'h081},
        '{8'h00, 8'h00, 4'h0, 24'h000278, 10'h081},
        '{8'h00, 8'h00, 4'h0, 24'h0003d4, 10'h041},
        '{8'h00, 8'h00, 4'h0, 24'h0003df, 10'h041},
        '{8'h00, 8'h00, 4'h0, 24'h0003e0, 10'h000},
        '{8'h00, 8'h00, 4'hc, 24'h0a0000, 10'h041},
        '{8'h00, 8'h00, 4'h8, 24'h0c0000, 10'h000},
        '{8'h00, 8'h00, 4'ha, 24'h0bfff0, 10'h000},
        '{8'h00, 8'h00, 4'h1, 24'h000170, 10'h011},
        '{8'h00, 8'h00, 4'h0, 24'h000300, 10'h101},
        '{8'h00, 8'h00, 4'h4, 24'h000300, 10'h000},
        '{8'h57, 8'h20, 4'h4, 24'h0003f5, 10'h000},
        '{8'h57, 8'h10, 4'h0, 24'h0001f0, 10'h000},
        '{8'h00, 8'h00, 4'h1, 24'h000377, 10'h011},
        '{8'h43, 8'h80, 4'h0, 24'h0003d4, 10'h000},
        '{8'h00, 8'h00, 4'h8, 24'h0a0000, 10'h041},
        '{8'h43, 8'h40, 4'h8, 24'h0a0000, 10'h000},
        '{8'h5f, 8'hc0, 4'h0, 24'h0003d4, 10'h000},
        '{8'h00, 8'h00, 4'h2, 24'h0003d4, 10'h041},
        '{8'h4e, 8'hfb, 4'h0, 24'h000060, 10'h020},
        '{8'h4e, 8'hbf, 4'h0, 24'h000300, 10'h100},
        '{8'h41, 8'h02, 4'h0, 24'h000060, 10'h221}
    };
    assign ev = {doze, cse[0], prn, vid, kbd, drv, dsk, sb, sa, idle};
    always #2 clk = ~clk;
    always @(posedge clk) begin
        seen <= clr ? 10'h000 : seen | ev;
        pulses <= clr ? 4'h0 : pulses + 4'(ev != 10'h000);
        hist <= clr ? 16'h0000 : {hist[13:0], ahold, smi};
    end
    pmaed_cpu_model cpu_u (.clk(clk), .hold(ahold), .valid(cyc_valid),
        .mem(cyc_mem), .write(cyc_write), .vlb(cyc_vlb), .ide(cyc_ide),
        .addr(cyc_addr));
    pmaed_decoder dut_u (.CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .CYC_VALID(cyc_valid), .CYC_MEM(cyc_mem),
        .CYC_WRITE(cyc_write), .CYC_VLB(cyc_vlb), .CYC_IDE_INT(cyc_ide),
        .CYC_ADDR(cyc_addr), .TIMER_TIMEOUT(tmo), .SERIAL_A_EVENT(sa),
        .SERIAL_B_EVENT(sb), .DISK_EVENT(dsk), .INTEGRATED_DRIVE_EVENT(drv),
        .KEYBOARD_EVENT(kbd), .VIDEO_EVENT(vid),
        .GENERAL_RANGE_ONE_EVENT(g1), .GENERAL_RANGE_TWO_EVENT(g2),
        .PRINTER_PORT_GROUP_EVENT(prn), .CHIP_SELECT_EVENT(cse),
        .CHIP_SELECT_LINES_N(csl), .IDLE_RELOAD(idle), .DOZE_RELOAD(doze),
        .GENERAL_RANGE_PMI(power_mgmt_interrupt), .NEXT_ACCESS_SMI(smi), .AHOLD(ahold));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run;
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, d);
    endtask : rd
    // Long cycle of three clocks must still give a single pulse
    task automatic run(input pmaed_row_type r);
        wr(r.ra, r.rd);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        cpu_u.cycle(r.kind, r.a, 3);
        repeat (3) @(posedge clk);
        #1;
        check(seen, r.ex);
        check(pulses, (r.ex != 10'h000) ? 4'h1 : 4'h0);
    endtask : run
    // History holds {hold, smi} pairs for five clocks from the hit
    task automatic trap(input logic [7:0] t, input logic [3:0] k,
                        input logic [23:0] a, input logic [9:0] exp);
        @(posedge clk);
        tmo <= t;
        clr <= 1'b1;
        @(posedge clk);
        tmo <= 8'h00;
        clr <= 1'b0;
        cpu_u.cycle(k, a, 1);
        repeat (4) @(posedge clk);
        #1;
        check(hist[9:0], exp);
    endtask : trap
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({ahold, smi, csl}, 6'h0f);
        rd(8'h43, 8'h00);
        rd(8'h57, 8'h00);
        rd(8'h5f, 8'h00);
        rd(8'hd5, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'hc0, 8'h3f);
        wr(8'h4e, 8'hff);
        wr(8'hbe, 8'hff);
        wr(8'h4a, 8'hc0);
        wr(8'h4b, 8'h20);
        wr(8'hac, 8'h04);
        foreach (rows[i]) run(rows[i]);
        rd(8'h43, 8'h40);
        wr(8'h5b, 8'h03);
        wr(8'hd5, 8'h01);
        trap(8'h01, 4'h2, 24'h0003d4, 10'h0ac);
        trap(8'h02, 4'h4, 24'h0003f5, 10'h040);
        trap(8'h00, 4'h2, 24'h0003d4, 10'h000);
        wr(8'h48, 8'hf4);
        wr(8'h49, 8'he3);
        wr(8'hae, 8'h29);
        wr(8'hb8, 8'h19);
        wr(8'hb9, 8'h40);
        wr(8'h5b, 8'h0b);
        // Dummy write starts range one before any timeout counts
        cpu_u.cycle(4'h4, 24'h0003ea, 1);
        #1;
        check({g1, g2, power_mgmt_interrupt}, 4'h8);
        @(posedge clk);
        tmo <= 8'h08;
        @(posedge clk);
        tmo <= 8'h00;
        #1;
        check(power_mgmt_interrupt, 2'h1);
        trap(8'h00, 4'h4, 24'h0003ea, 10'h040);
        trap(8'h08, 4'h0, 24'h0003ea, 10'h000);
        cpu_u.cycle(4'hc, 24'h0cc010, 1);
        #1;
        check({g1, g2, power_mgmt_interrupt}, 4'h4);
        cpu_u.cycle(4'h8, 24'h0cc010, 1);
        #1;
        check({g1, g2, power_mgmt_interrupt}, 4'h0);
        complete_run();
    end
endmodule : testbench
